/* verilog/pdmc_defines.svh */
// Offsets, bit positions, reset values and counts of the power-down block.
`ifndef PDMC_DEFINES_SVH
`define PDMC_DEFINES_SVH
`define PDMC_CTRL_OFFSET     32'h05ffffbc
`define PDMC_CTRL_RESET      8'h1f
`define PDMC_BIT_DEEP        7
`define PDMC_BIT_FLOAT       6
`define PDMC_BIT_ZERO        5
`define PDMC_FIXED_ONES      8'h1f
`define PDMC_STATUS_OFFSET   32'h05ffffc0
`define PDMC_WDOG_DEFAULT    16'h00ff
`endif

/* verilog/pdmc_pkg.sv */
// Types shared by the power-down controller files.
package pdmc_pkg;
  typedef enum logic [2:0] {
    PDMC_RUN,
    PDMC_LIGHT,
    PDMC_DEEP,
    PDMC_SETTLE
  } pdmc_state_t;

  typedef enum logic [2:0] {
    PDMC_WAKE_NONE,
    PDMC_WAKE_IRQ,
    PDMC_WAKE_DMA_ERR,
    PDMC_WAKE_NMI,
    PDMC_WAKE_POR,
    PDMC_WAKE_MANUAL
  } pdmc_wake_t;

  typedef struct packed {
    logic       paddr_ok;
    logic [7:0] pwdata_b;
  } pdmc_wr_t;

  typedef struct packed {
    logic       cpu_stall;
    logic       clk_run;
    logic       periph_run;
    logic       wdog_clk_only;
    logic       port_hold;
    logic       port_float;
  } pdmc_ctl_t;
endpackage

/* verilog/pdmc_sync.sv */
// Two flip-flop synchroniser for one level from outside the clock domain.
`timescale 1ns/1ns
module pdmc_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic din,
  output logic      dout
);
  logic meta_reg;
  logic meta_next;
  logic dout_reg;
  logic dout_next;

  always_comb begin
    meta_next = din;
    dout_next = meta_reg;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      meta_reg <= RESET_VAL;
      dout_reg <= RESET_VAL;
    end else begin
      meta_reg <= meta_next;
      dout_reg <= dout_next;
    end
  end

  assign dout = dout_reg;
endmodule

/* verilog/pdmc_top.sv */
// Power-down mode controller: light halt, deep halt and their wake events.
// Behaviour
// RULE_01: Halt strobe with deep select 0 enters light halt; CPU stops.
// RULE_02: Light halt keeps peripherals and system clock running.
// RULE_03: Halt strobe with deep select 1 enters deep halt, stopping clock.
// RULE_04: Control register is 8 bits, read/write, reset value 1f hex.
// RULE_05: Bit 7 deep select cannot be set while watchdog runs.
// RULE_06: Bit 6 port float cannot be set while watchdog runs.
// RULE_07: Deep halt holds ports when float is 0, floats them when 1.
// RULE_08: Bit 5 reads zero, is read only; software writes zero.
// RULE_09: Bits 4 to 0 ignore writes and read as one.
// RULE_10: An accepted interrupt ends light halt; interrupt handling starts.
// RULE_11: Interrupt at or below the status word mask does not wake.
// RULE_12: Interrupt disabled in its peripheral does not wake.
// RULE_13: DMA address error ends light halt and starts its exception.
// RULE_14: Reset pin falling with NMI high gives power-on reset.
// RULE_15: Reset pin falling with NMI low gives manual reset.
// RULE_16: NMI edge of the selected polarity raises NMI, waking light halt.
// RULE_17: Deep halt ends only on NMI, power-on or manual reset.
// RULE_18: NMI wake from deep halt clocks watchdog only until overflow; the code also releases the clock when the WDOG_SETTLE count runs out.
// RULE_19: Halt request is a one-cycle strobe; deep select sampled then.
//
// Local design decision: register access over APB.
`timescale 1ns/1ns
`include "pdmc_defines.svh"
module pdmc_top #(
  parameter logic [15:0] WDOG_SETTLE = `PDMC_WDOG_DEFAULT
) (
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              halt_req,
  input  wire logic              watchdog_run_enable,
  input  wire logic              watchdog_overflow,
  input  wire logic              irq_req,
  input  wire logic [3:0]        irq_level,
  input  wire logic              irq_src_enabled,
  input  wire logic [3:0]        cpu_status_word_mask,
  input  wire logic              dma_addr_err,
  input  wire logic              nonmaskable_edge_select,
  input  wire logic              nmi_pin,
  input  wire logic              chip_init_in_n,
  output pdmc_pkg::pdmc_ctl_t    ctl,
  output pdmc_pkg::pdmc_wake_t   wake_cause,
  output logic                   wake_pulse
);
  import pdmc_pkg::*;

  logic        nmi_s;
  logic        init_n_s;
  pdmc_state_t state_reg;
  pdmc_state_t state_next;
  logic [7:0]  ctrl_reg;
  logic [7:0]  ctrl_next;
  logic        nmi_d_reg;
  logic        nmi_d_next;
  logic        init_d_reg;
  logic        init_d_next;
  pdmc_wake_t  cause_reg;
  pdmc_wake_t  cause_next;
  logic        wake_reg;
  logic        wake_next;
  pdmc_ctl_t   ctl_reg;
  pdmc_ctl_t   ctl_next;
  logic [15:0] settle_reg;
  logic [15:0] settle_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic        nmi_edge;
  logic        init_fall;
  logic        irq_ok;
  logic        wr_ctrl;
  logic        addr_ctrl;
  logic        addr_stat;

  // Pins come from outside the clock domain, so they are synchronised first.
  pdmc_sync #(.RESET_VAL(1'b0)) u_sync_nmi (
    .clk  (clk),
    .srst (srst),
    .din  (nmi_pin),
    .dout (nmi_s)
  );
  pdmc_sync #(.RESET_VAL(1'b1)) u_sync_init (
    .clk  (clk),
    .srst (srst),
    .din  (chip_init_in_n),
    .dout (init_n_s)
  );

  assign addr_ctrl = (paddr == `PDMC_CTRL_OFFSET);
  assign addr_stat = (paddr == `PDMC_STATUS_OFFSET);
  assign pready    = 1'b1;
  assign pslverr   = psel & penable & ~(addr_ctrl | addr_stat);
  assign wr_ctrl   = psel & penable & pwrite & addr_ctrl & pstrb[0];
  assign prdata    = prdata_reg;

  // The selected edge is high for rising, low for falling.
  assign nmi_edge  = nonmaskable_edge_select ? (nmi_s & ~nmi_d_reg)
                                             : (~nmi_s & nmi_d_reg); // RULE_16
  assign init_fall = init_d_reg & ~init_n_s;
  assign irq_ok    = irq_req & irq_src_enabled                       // RULE_12
                     & (irq_level > cpu_status_word_mask);           // RULE_11

  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl) begin
      // An ignored attempt to set keeps the old bit; clearing always works.
      ctrl_next[`PDMC_BIT_DEEP]  = pwdata[`PDMC_BIT_DEEP]
                                   & (ctrl_reg[`PDMC_BIT_DEEP]
                                      | ~watchdog_run_enable);       // RULE_05
      ctrl_next[`PDMC_BIT_FLOAT] = pwdata[`PDMC_BIT_FLOAT]
                                   & (ctrl_reg[`PDMC_BIT_FLOAT]
                                      | ~watchdog_run_enable);       // RULE_06
    end
    ctrl_next[`PDMC_BIT_ZERO] = 1'b0;                                // RULE_08
    ctrl_next[4:0] = 5'(`PDMC_FIXED_ONES);                           // RULE_09
  end

  always_comb begin
    prdata_next = 32'h0000_0000;
    if (psel & ~penable & ~pwrite & addr_ctrl)
      prdata_next = {24'h000000, ctrl_reg};                         // RULE_04
    else if (psel & ~penable & ~pwrite & addr_stat)
      prdata_next = {26'h0, 3'(cause_reg), 3'(state_reg)};
  end

  always_comb begin
    state_next  = state_reg;
    cause_next  = cause_reg;
    wake_next   = 1'b0;
    settle_next = settle_reg;
    nmi_d_next  = nmi_s;
    init_d_next = init_n_s;
    case (state_reg)
      PDMC_RUN: begin
        if (halt_req) begin
          // Deep select is sampled on the strobe cycle itself.
          if (ctrl_reg[`PDMC_BIT_DEEP])                              // RULE_19
            state_next = PDMC_DEEP;                                  // RULE_03
          else
            state_next = PDMC_LIGHT;                                 // RULE_01
        end
      end
      PDMC_LIGHT: begin
        if (init_fall) begin
          state_next = PDMC_RUN;
          cause_next = nmi_s ? PDMC_WAKE_POR                         // RULE_14
                             : PDMC_WAKE_MANUAL;                     // RULE_15
          wake_next  = 1'b1;
        end else if (nmi_edge) begin
          state_next = PDMC_RUN;
          cause_next = PDMC_WAKE_NMI;                                // RULE_16
          wake_next  = 1'b1;
        end else if (dma_addr_err) begin
          state_next = PDMC_RUN;
          cause_next = PDMC_WAKE_DMA_ERR;                            // RULE_13
          wake_next  = 1'b1;
        end else if (irq_ok) begin
          state_next = PDMC_RUN;
          cause_next = PDMC_WAKE_IRQ;                                // RULE_10
          wake_next  = 1'b1;
        end
      end
      PDMC_DEEP: begin
        // Ordinary interrupts and DMA errors are deliberately ignored here.
        if (init_fall) begin                                         // RULE_17
          state_next = PDMC_RUN;
          cause_next = nmi_s ? PDMC_WAKE_POR                         // RULE_14
                             : PDMC_WAKE_MANUAL;                     // RULE_15
          wake_next  = 1'b1;
        end else if (nmi_edge) begin
          state_next  = PDMC_SETTLE;                                 // RULE_18
          settle_next = WDOG_SETTLE;
        end
      end
      PDMC_SETTLE: begin
        // Overflow of the watchdog, or the fallback count, releases the clock.
        if (settle_reg != 16'h0000)
          settle_next = settle_reg - 16'h0001;
        if (watchdog_overflow | (settle_reg == 16'h0000)) begin     // RULE_18
          state_next = PDMC_RUN;
          cause_next = PDMC_WAKE_NMI;
          wake_next  = 1'b1;
        end
      end
      default: state_next = PDMC_RUN;
    endcase
  end

  always_comb begin
    ctl_next               = '0;
    ctl_next.cpu_stall     = (state_next != PDMC_RUN);
    ctl_next.clk_run       = (state_next == PDMC_RUN)
                             | (state_next == PDMC_LIGHT);           // RULE_02
    ctl_next.periph_run    = ctl_next.clk_run;                       // RULE_02
    ctl_next.wdog_clk_only = (state_next == PDMC_SETTLE);            // RULE_18
    ctl_next.port_float    = (state_next == PDMC_DEEP)
                             & ctrl_reg[`PDMC_BIT_FLOAT];            // RULE_07
    ctl_next.port_hold     = (state_next == PDMC_DEEP)
                             & ~ctrl_reg[`PDMC_BIT_FLOAT];           // RULE_07
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg  <= PDMC_RUN;
      ctrl_reg   <= `PDMC_CTRL_RESET;                                // RULE_04
      nmi_d_reg  <= 1'b0;
      init_d_reg <= 1'b1;
      cause_reg  <= PDMC_WAKE_NONE;
      wake_reg   <= 1'b0;
      settle_reg <= 16'h0000;
      prdata_reg <= 32'h0000_0000;
      ctl_reg    <= '0;
    end else begin
      state_reg  <= state_next;
      ctrl_reg   <= ctrl_next;
      nmi_d_reg  <= nmi_d_next;
      init_d_reg <= init_d_next;
      cause_reg  <= cause_next;
      wake_reg   <= wake_next;
      settle_reg <= settle_next;
      prdata_reg <= prdata_next;
      ctl_reg    <= ctl_next;
    end
  end

  assign ctl        = ctl_reg;
  assign wake_cause = cause_reg;
  assign wake_pulse = wake_reg;

  // The halt stall must appear one cycle after the strobe.
  property p_light_entry;
    @(posedge clk) disable iff (srst)
      (state_reg == PDMC_RUN && halt_req && !ctrl_reg[7])
      |=> (state_reg == PDMC_LIGHT) && ctl.cpu_stall && ctl.clk_run;
  endproperty
  a_light_entry: assert property (p_light_entry) // RULE_01
    else $error("light halt not entered");

  property p_deep_entry;
    @(posedge clk) disable iff (srst)
      (state_reg == PDMC_RUN && halt_req && ctrl_reg[7])
      |=> (state_reg == PDMC_DEEP) && !ctl.clk_run && !ctl.periph_run;
  endproperty
  a_deep_entry: assert property (p_deep_entry) // RULE_03
    else $error("deep halt not entered");

  property p_fixed_bits;
    @(posedge clk) disable iff (srst)
      ##1 (ctrl_reg[5:0] == 6'h1f);
  endproperty
  a_fixed_bits: assert property (p_fixed_bits) // RULE_09
    else $error("fixed control bits wrong");

  property p_deep_locked;
    @(posedge clk) disable iff (srst)
      (wr_ctrl && watchdog_run_enable && !ctrl_reg[7]) |=> !ctrl_reg[7];
  endproperty
  a_deep_locked: assert property (p_deep_locked) // RULE_05
    else $error("deep select set while watchdog runs");

  property p_float_locked;
    @(posedge clk) disable iff (srst)
      (wr_ctrl && watchdog_run_enable && !ctrl_reg[6]) |=> !ctrl_reg[6];
  endproperty
  a_float_locked: assert property (p_float_locked) // RULE_06
    else $error("float select set while watchdog runs");

  property p_deep_no_irq;
    @(posedge clk) disable iff (srst)
      (state_reg == PDMC_DEEP && !nmi_edge && !init_fall)
      |=> (state_reg == PDMC_DEEP);
  endproperty
  a_deep_no_irq: assert property (p_deep_no_irq) // RULE_17
    else $error("deep halt left without cause");

  property p_masked_irq;
    @(posedge clk) disable iff (srst)
      (state_reg == PDMC_LIGHT && !nmi_edge && !init_fall && !dma_addr_err
       && (irq_level <= cpu_status_word_mask)) |=> (state_reg == PDMC_LIGHT);
  endproperty
  a_masked_irq: assert property (p_masked_irq) // RULE_11
    else $error("masked interrupt woke light halt");

  property p_dma_wake;
    @(posedge clk) disable iff (srst)
      (state_reg == PDMC_LIGHT && dma_addr_err && !nmi_edge && !init_fall)
      |=> wake_pulse && (wake_cause == PDMC_WAKE_DMA_ERR);
  endproperty
  a_dma_wake: assert property (p_dma_wake) // RULE_13
    else $error("dma error wake missing");

  property p_por_wake;
    @(posedge clk) disable iff (srst)
      (state_reg == PDMC_LIGHT && init_fall && nmi_s)
      |=> wake_pulse && (wake_cause == PDMC_WAKE_POR);
  endproperty
  a_por_wake: assert property (p_por_wake) // RULE_14
    else $error("power-on reset wake missing");

  property p_settle_wdog;
    @(posedge clk) disable iff (srst)
      (state_reg == PDMC_DEEP && nmi_edge && !init_fall)
      |=> ctl.wdog_clk_only && !ctl.clk_run;
  endproperty
  a_settle_wdog: assert property (p_settle_wdog) // RULE_18
    else $error("watchdog-only clock missing");
endmodule

/* bench/pdmc_cpu_model.sv */
// Model of the CPU halt strobe and of the watchdog overflow after a wake.
`timescale 1ns/1ns
module pdmc_cpu_model #(
  parameter int OVF_DLY = 2
) (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic go,
  input  wire logic wdog_clk_only,
  output logic      halt_req,
  output logic      watchdog_overflow
);
  int cnt;
  // The strobe lasts one cycle even if go were held, as a real core would.
  always_ff @(posedge clk) begin
    halt_req <= go & ~halt_req & ~srst;
  end
  // The watchdog only counts while it alone is clocked, then overflows once.
  always_ff @(posedge clk) begin
    if (srst || !wdog_clk_only) begin
      cnt               <= 0;
      watchdog_overflow <= 1'b0;
    end else begin
      cnt               <= cnt + 1;
      watchdog_overflow <= (cnt == OVF_DLY);
    end
  end
endmodule

/* bench/power_down_mode_control_bench.sv */
// Self-checking bench for the power-down mode controller.
`timescale 1ns/1ns
module power_down_mode_control_bench;
  import pdmc_pkg::*;
  localparam logic [31:0] CTRL = 32'h05ffffbc;
  logic        clk, srst, psel, penable, pwrite, go, pready, pslverr;
  logic        halt_req, wre, wovf, irq, ien, dma, nes, nmi, rst_n, wp, er;
  logic [31:0] paddr, pwdata, prdata, rd, d;
  logic [3:0]  pstrb, ilvl, mask;
  pdmc_ctl_t   ctl;
  pdmc_wake_t  cause;
  int          fails, num_checks, m;

  pdmc_top #(.WDOG_SETTLE(16'h0004)) u_pdmc_top (
    .clk(clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .halt_req(halt_req), .watchdog_run_enable(wre),
    .watchdog_overflow(wovf), .irq_req(irq), .irq_level(ilvl),
    .irq_src_enabled(ien), .cpu_status_word_mask(mask),
    .dma_addr_err(dma), .nonmaskable_edge_select(nes), .nmi_pin(nmi),
    .chip_init_in_n(rst_n), .ctl(ctl), .wake_cause(cause),
    .wake_pulse(wp));
  pdmc_cpu_model u_pdmc_cpu_model (
    .clk(clk), .srst(srst), .go(go), .wdog_clk_only(ctl.wdog_clk_only),
    .halt_req(halt_req), .watchdog_overflow(wovf));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic finish_test(bit to);
    if (to) fails++;
    if (fails == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic apb(bit w, logic [31:0] a, logic [31:0] wd);
    int i;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 20) finish_test(1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // Watches for a wake pulse; ex says whether one must come within lim.
  task automatic wt(int lim, bit ex, pdmc_wake_t e);
    bit f;
    f = 1'b0;
    for (int i = 0; i < lim && !f; i++) begin
      @(negedge clk);
      f = (wp === 1'b1);
    end
    chk("wake", f, ex);
    if (ex) chk("cause", cause, e);
    if (ex) chk("stall", ctl.cpu_stall, 1'b0);
    @(posedge clk);
  endtask

  task automatic halt();
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (3) @(negedge clk);
    chk("halted", ctl.cpu_stall, 1'b1);
    @(posedge clk);
  endtask

  initial begin
    {psel, penable, pwrite, go, wre, irq, ien, dma, nes, nmi} = '0;
    {paddr, pwdata, ilvl, mask} = '0;
    pstrb = 4'hf;
    rst_n = 1'b1;
    srst  = 1'b1;
    fails = 0;
    num_checks = 0;
    m = 'h1f;
    void'($urandom(32'h5b95));
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    repeat (3) @(posedge clk);
    apb(1'b0, CTRL, 32'h0);
    chk("ctrl_reset", rd, 32'h1f);
    apb(1'b0, 32'h0, 32'h0);
    chk("unmapped", er, 1'b1);
    for (int k = 0; k < 16; k++) begin
      d = $urandom & ~32'h20;
      wre   <= 1'($urandom % 2);
      pstrb <= 4'he | 4'($urandom % 2);
      @(posedge clk);
      if (pstrb[0] && wre) m = m & ({24'h0, d[7:6], 6'h3f});
      if (pstrb[0] && !wre) m = {d[7:6], 6'h1f};
      apb(1'b1, CTRL, d);
      apb(1'b0, CTRL, 32'h0);
      chk("ctrl", rd, m);
    end
    wre   <= 1'b0;
    pstrb <= 4'hf;
    apb(1'b1, CTRL, 32'h0);
    halt();
    chk("clocks", {ctl.clk_run, ctl.periph_run}, 2'b11);
    mask <= 4'($urandom % 15);
    irq  <= 1'b1;
    ien  <= 1'b1;
    @(posedge clk);
    ilvl <= 4'($urandom % (mask + 1));
    wt(10, 1'b0, PDMC_WAKE_NONE);
    ilvl <= mask + 4'h1 + 4'($urandom % (15 - mask));
    ien  <= 1'b0;
    wt(10, 1'b0, PDMC_WAKE_NONE);
    ien <= 1'b1;
    wt(4, 1'b1, PDMC_WAKE_IRQ);
    irq <= 1'b0;
    halt();
    dma <= 1'b1;
    wt(4, 1'b1, PDMC_WAKE_DMA_ERR);
    dma <= 1'b0;
    nes <= 1'b1;
    halt();
    nmi <= 1'b1;
    wt(8, 1'b1, PDMC_WAKE_NMI);
    halt();
    rst_n <= 1'b0;
    wt(8, 1'b1, PDMC_WAKE_POR);
    rst_n <= 1'b1;
    nmi   <= 1'b0;
    repeat (6) @(posedge clk);
    halt();
    rst_n <= 1'b0;
    wt(8, 1'b1, PDMC_WAKE_MANUAL);
    rst_n <= 1'b1;
    apb(1'b0, 32'h05ffffc0, 32'h0);
    chk("status", rd, 32'h28);
    apb(1'b1, CTRL, 32'hc0);
    halt();
    chk("float", {ctl.port_float, ctl.port_hold}, 2'b10);
    irq <= 1'b1;
    wt(10, 1'b0, PDMC_WAKE_NONE);
    nmi <= 1'b1;
    for (int i = 0; i < 10 && ctl.wdog_clk_only !== 1'b1; i++) begin
      @(negedge clk);
    end
    chk("wdog_only", ctl.wdog_clk_only, 1'b1);
    wt(20, 1'b1, PDMC_WAKE_NMI);
    irq <= 1'b0;
    apb(1'b1, CTRL, 32'h80);
    halt();
    chk("hold", {ctl.port_float, ctl.port_hold}, 2'b01);
    rst_n <= 1'b0;
    wt(8, 1'b1, PDMC_WAKE_POR);
    rst_n <= 1'b1;
    finish_test(1'b0);
  end
endmodule
